// *** rtl/cond_ctrl_map.svh ***
`ifndef COND_CTRL_MAP_SVH
`define COND_CTRL_MAP_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_CTRL       12'h000
`define ADDR_STATUS     12'h004
`define ADDR_LIMITS     12'h008
`define ADDR_RAW        12'h00c
`define ADDR_RESULT     12'h010
`define ADDR_COEF       12'h014
`define ADDR_ERRCODE    12'h018

// ****************************************************************
// ctrl fields
// ****************************************************************
`define CTRL_POC_BIT      0
`define CTRL_ROMCHK_BIT   1
`define CTRL_MODE_LSB     2
`define CTRL_TSRC_LSB     4
`define CTRL_RES_LSB      6
`define CTRL_SIGOK_BIT    8
`define CTRL_CMD_BIT      9
`define CTRL_ERR_BIT      10
`define CTRL_RESET        32'h0000_0000

// ****************************************************************
// limits, error code, timing
// ****************************************************************
`define LIM_LO_RESET      15'h0000
`define LIM_HI_RESET      15'h7fff
`define DIAG_ERR_CODE     16'hdead
`define DAC_MIN           15'h0000
`define CLK_HZ            100000000
`define REF_CLK_HZ        3000000
`define ROMCHK_CLOCKS     28180
`define EE_READ_US        200
`define ANALOG_OUTPUT_PIN_ON_US        2000
`define WINDOW_MS         500
`define AD_CONV_CLOCKS    1024
`define START_CONVS       5

`endif

// *** rtl/cond_ctrl_pkg.sv ***
package cond_ctrl_pkg;

  typedef enum logic [5:0] {
    st_poc    = 6'h01,
    st_eeprom = 6'h02,
    st_start  = 6'h04,
    st_nom    = 6'h08,
    st_cmd    = 6'h10,
    st_diag   = 6'h20
  } ctrl_state_e;

  typedef enum logic [1:0] {
    onewire_always_mode     = 2'h0,
    onewire_disabled_mode   = 2'h1,
    window_only_mode        = 2'h2,
    analog_with_window_mode = 2'h3
  } out_mode_e;

  typedef enum logic [1:0] {
    tsrc_internal_junction = 2'h0,
    tsrc_bridge_top        = 2'h1,
    tsrc_half_bridge       = 2'h2,
    tsrc_bridge_tc         = 2'h3
  } temp_src_e;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

endpackage

// *** rtl/conditioner_mode_startup_control.sv ***
// Function
// - three main states: normal conditioning, command, diagnostic
// - phase one holds reset until power-on clear releases; pin tristated
// - phase two reads eeprom, checks signature, rom check 28180 clocks if enabled
// - phase three runs start routine, about five conversion times
// - phase three drives low in analog/disabled modes, tristate otherwise
// - end of start-up activates output per mode, or diagnostic on error
// - after start-up, measurement cycle repeats without external action
// - sixteen-bit correction on every measured signal using stored coefficients
// - correction applies gain and nonlinearity terms up to third order
// - result is unsigned fifteen-bit fraction in zero to one
// - result clipped to limits, written to serial register and dac
// - correction input at most fourteen bits; 15/16-bit modes use segment
// - always mode keeps analog off, accepts one-wire always
// - disabled mode activates analog about 2 ms, ignores one-wire
// - window-only mode accepts one-wire in 500 ms window, then analog
// - analog-with-window drives analog from 2 ms, accepts one-wire 500 ms
// - dac fed with clipped result through unity-gain buffer
// - serial interface supports two-wire and one-wire protocols
// - one of four temperature sources chosen from configuration
// - start-up durations scale with clock except conversion time (fixed clock count); figures given at 3 MHz
// - diagnostic forces output minimum and loads error code
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cond_ctrl_map.svh"

module conditioner_mode_startup_control #(
  parameter int unsigned CLK_HZ         = `CLK_HZ,
  parameter int unsigned ROMCHK_CYC     = `ROMCHK_CLOCKS * (CLK_HZ / `REF_CLK_HZ),
  parameter int unsigned EE_CYC         = `EE_READ_US * (CLK_HZ / 1000000),
  parameter int unsigned ANALOG_OUTPUT_PIN_ON_CYC    = `ANALOG_OUTPUT_PIN_ON_US * (CLK_HZ / 1000000),
  parameter int unsigned WINDOW_CYC     = `WINDOW_MS * (CLK_HZ / 1000),
  parameter int unsigned AD_CONV_CYC    = `AD_CONV_CLOCKS,
  parameter int unsigned CNT_W          = 27
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite slave
  input  wire logic [11:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output var  logic          s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output var  logic          s_axi_wready,
  output var  logic [1:0]    s_axi_bresp,
  output var  logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [11:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output var  logic          s_axi_arready,
  output var  logic [31:0]   s_axi_rdata,
  output var  logic [1:0]    s_axi_rresp,
  output var  logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // link and pins
  input  wire logic          onewire_cmd_valid,
  input  wire logic          i2c_cmd_valid,
  output var  logic          analog_out_enable,
  output var  logic          analog_out_low,
  output var  logic [14:0]   dac_code,
  output var  logic [15:0]   serial_out,
  output var  logic          onewire_accept,
  output var  logic [1:0]    temp_source_sel,
  output var  logic [5:0]    state_out
);

  // ****************************************************************
  // state and registers
  // ****************************************************************
  cond_ctrl_pkg::ctrl_state_e state_r, state_nxt;
  logic [31:0]      ctrl_r;
  logic [14:0]      lim_lo_r;
  logic [14:0]      lim_hi_r;
  logic [15:0]      raw_r;
  logic [15:0]      coef_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] up_r;
  logic [2:0]       conv_r;
  logic             romchk_done_r;
  logic             cmd_r;

  // ****************************************************************
  // decoding
  // ****************************************************************
  wire       poc_released  = ctrl_r[`CTRL_POC_BIT];
  wire       rom_check_enable = ctrl_r[`CTRL_ROMCHK_BIT];
  wire [1:0] mode_bits     = ctrl_r[`CTRL_MODE_LSB +: 2];
  wire [1:0] res_bits      = ctrl_r[`CTRL_RES_LSB +: 2];
  wire       sig_ok        = ctrl_r[`CTRL_SIGOK_BIT];
  wire       err_flag      = ctrl_r[`CTRL_ERR_BIT];
  wire       m_always      = mode_bits == 2'(cond_ctrl_pkg::onewire_always_mode);
  wire       m_disabled    = mode_bits == 2'(cond_ctrl_pkg::onewire_disabled_mode);
  wire       m_window      = mode_bits == 2'(cond_ctrl_pkg::window_only_mode);
  wire       m_anawin      = mode_bits == 2'(cond_ctrl_pkg::analog_with_window_mode);
  wire       in_window     = up_r < CNT_W'(WINDOW_CYC);
  wire       past_2ms      = up_r >= CNT_W'(ANALOG_OUTPUT_PIN_ON_CYC);
  // one-wire acceptance by mode
  wire       ow_open       = m_always |
                             ((m_window | m_anawin) & in_window);
  // serial interface: two-wire always, one-wire gated by mode
  wire       enter_cmd     = i2c_cmd_valid | (onewire_cmd_valid & ow_open);
  wire       ee_time_done  = cnt_r >= CNT_W'(EE_CYC);
  wire       rom_time_done = cnt_r >= CNT_W'(ROMCHK_CYC);
  wire       start_done    = conv_r == 3'(`START_CONVS);
  wire       conv_tick     = cnt_r >= CNT_W'(AD_CONV_CYC - 1);

  // ****************************************************************
  // correction path
  // ****************************************************************
  // fourteen-bit segment of converter range
  wire [13:0] corr_in = (res_bits[1]) ? raw_r[15:2] : raw_r[13:0];
  // sixteen-bit gain with square and cube terms
  wire signed [15:0] x_s   = $signed({2'h0, corr_in});
  wire signed [31:0] lin   = x_s * $signed(coef_r);
  wire signed [31:0] sq    = (x_s * x_s) >>> 14;
  wire signed [31:0] cube  = ($signed(sq[15:0]) * x_s) >>> 14;
  wire signed [31:0] sum   = (lin >>> 14) + (sq >>> 3) - (cube >>> 4);
  // unsigned fraction in [0;1)
  wire [14:0] frac = sum[31] ? 15'h0000 : (|sum[30:15] ? 15'h7fff : sum[14:0]);
  wire [14:0] clipped = (frac < lim_lo_r) ? lim_lo_r :
                        ((frac > lim_hi_r) ? lim_hi_r : frac);

  // ****************************************************************
  // state machine
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cond_ctrl_pkg::st_poc: begin
        if (poc_released) begin
          state_nxt = cond_ctrl_pkg::st_eeprom;
        end
      end
      cond_ctrl_pkg::st_eeprom: begin
        if (ee_time_done && (!rom_check_enable || romchk_done_r)) begin
          state_nxt = sig_ok ? cond_ctrl_pkg::st_start : cond_ctrl_pkg::st_diag;
        end
      end
      cond_ctrl_pkg::st_start: begin
        if (start_done) begin
          state_nxt = err_flag ? cond_ctrl_pkg::st_diag : cond_ctrl_pkg::st_nom;
        end
      end
      cond_ctrl_pkg::st_nom: begin
        if (err_flag) begin
          state_nxt = cond_ctrl_pkg::st_diag;
        end else if (enter_cmd) begin
          state_nxt = cond_ctrl_pkg::st_cmd;
        end
      end
      cond_ctrl_pkg::st_cmd: begin
        state_nxt = cond_ctrl_pkg::st_cmd;
      end
      cond_ctrl_pkg::st_diag: begin
        state_nxt = cond_ctrl_pkg::st_diag;
      end
      default: state_nxt = cond_ctrl_pkg::st_poc;
    endcase
  end

  wire leaving = state_nxt != state_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= cond_ctrl_pkg::st_poc;
    end else if (!poc_released) begin
      state_r <= cond_ctrl_pkg::st_poc;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  // phase counter, scaled by clock rate
  always_ff @(posedge aclk) begin
    if (!aresetn || leaving) begin
      cnt_r <= '0;
    end else if (state_r == cond_ctrl_pkg::st_start && conv_tick) begin
      cnt_r <= '0;
    end else if (!(&cnt_r)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !poc_released) begin
      up_r <= '0;
    end else if (!(&up_r)) begin
      up_r <= up_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != cond_ctrl_pkg::st_start) begin
      conv_r <= '0;
    end else if (conv_tick && !start_done) begin
      conv_r <= conv_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_r == cond_ctrl_pkg::st_poc) begin
      romchk_done_r <= 1'b0;
    end else if (state_r == cond_ctrl_pkg::st_eeprom && rom_time_done) begin
      romchk_done_r <= 1'b1;
    end
  end

  // ****************************************************************
  // result path and pins
  // ****************************************************************
  wire run_nom   = state_r == cond_ctrl_pkg::st_nom;
  wire is_diag   = state_r == cond_ctrl_pkg::st_diag;
  wire ana_ok    = run_nom & !m_always & (m_disabled | m_anawin ? past_2ms : !in_window);
  wire drive_low = state_r == cond_ctrl_pkg::st_eeprom | is_diag |
                   (state_r == cond_ctrl_pkg::st_start & (m_anawin | m_disabled));
  cond_ctrl_pkg::pin_drive_s pin_nxt;
  assign pin_nxt.oe  = ana_ok | drive_low;
  assign pin_nxt.out = ana_ok & !drive_low;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_code          <= `DAC_MIN;
      serial_out        <= '0;
      analog_out_enable <= 1'b0;
      analog_out_low    <= 1'b0;
      onewire_accept    <= 1'b0;
      temp_source_sel   <= '0;
      state_out         <= cond_ctrl_pkg::st_poc;
      cmd_r             <= 1'b0;
    end else begin
      analog_out_enable <= pin_nxt.oe;
      analog_out_low    <= pin_nxt.oe & !pin_nxt.out;
      onewire_accept    <= ow_open & (run_nom | state_r == cond_ctrl_pkg::st_start);
      temp_source_sel   <= ctrl_r[`CTRL_TSRC_LSB +: 2];
      state_out         <= state_r;
      cmd_r             <= state_r == cond_ctrl_pkg::st_cmd;
      if (is_diag) begin
        dac_code   <= `DAC_MIN;
        serial_out <= `DIAG_ERR_CODE;
      end else if (run_nom) begin
        dac_code   <= clipped;
        serial_out <= {1'b0, clipped};
      end
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic        aw_got_r, w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  wire         do_write = aw_got_r & w_got_r & !s_axi_bvalid;
  wire         wr_ctrl  = do_write & (awaddr_r == `ADDR_CTRL);
  wire         wr_lim   = do_write & (awaddr_r == `ADDR_LIMITS);
  wire         wr_raw   = do_write & (awaddr_r == `ADDR_RAW);
  wire         wr_coef  = do_write & (awaddr_r == `ADDR_COEF);
  wire         wr_hit   = wr_ctrl | wr_lim | wr_raw | wr_coef;
  wire [31:0]  status_w = {25'h0, cmd_r, state_r};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    return old;
  endfunction

  wire [31:0]  lo_m     = merge({17'h0, lim_lo_r}, {17'h0, wdata_r[14:0]}, wstrb_r & 4'h3);
  wire [31:0]  hi_m     = merge({17'h0, lim_hi_r}, {17'h0, wdata_r[30:16]}, {2'h0, wstrb_r[3:2]});
  wire [31:0]  raw_m    = merge({16'h0, raw_r}, wdata_r, wstrb_r);
  wire [31:0]  coef_m   = merge({16'h0, coef_r}, wdata_r, wstrb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= `CTRL_RESET;
      lim_lo_r <= `LIM_LO_RESET;
      lim_hi_r <= `LIM_HI_RESET;
      raw_r    <= '0;
      coef_r   <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
      end
      if (wr_lim) begin
        lim_lo_r <= lo_m[14:0];
        lim_hi_r <= hi_m[14:0];
      end
      if (wr_raw) begin
        raw_r <= raw_m[15:0];
      end
      if (wr_coef) begin
        coef_r <= coef_m[15:0];
      end
    end
  end

  wire        rd_take = s_axi_arvalid & s_axi_arready;
  wire        rd_hit  = (s_axi_araddr == `ADDR_CTRL) | (s_axi_araddr == `ADDR_STATUS) |
                        (s_axi_araddr == `ADDR_LIMITS) | (s_axi_araddr == `ADDR_RAW) |
                        (s_axi_araddr == `ADDR_RESULT) | (s_axi_araddr == `ADDR_COEF) |
                        (s_axi_araddr == `ADDR_ERRCODE);
  wire [31:0] rd_mux  =
    (s_axi_araddr == `ADDR_CTRL)    ? ctrl_r :
    (s_axi_araddr == `ADDR_STATUS)  ? status_w :
    (s_axi_araddr == `ADDR_LIMITS)  ? {1'b0, lim_hi_r, 1'b0, lim_lo_r} :
    (s_axi_araddr == `ADDR_RAW)     ? {16'h0, raw_r} :
    (s_axi_araddr == `ADDR_RESULT)  ? {16'h0, serial_out} :
    (s_axi_araddr == `ADDR_COEF)    ? {16'h0, coef_r} :
    (s_axi_araddr == `ADDR_ERRCODE) ? {16'h0, `DIAG_ERR_CODE} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'h0;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** testbench/cond_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module cond_ctrl_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [5:0]  state_out,
  input wire logic        analog_out_enable,
  input wire logic        analog_out_low,
  input wire logic [14:0] dac_code,
  input wire logic [15:0] serial_out,
  input wire logic        onewire_accept,
  input wire logic        onewire_cmd_valid,
  input wire logic        i2c_cmd_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // state and pin
  // ****
  state_code_a: assert property ($onehot(state_out))
    else $error("state code not one-hot");
  reset_state_a: assert property ($rose(aresetn)
    |-> state_out == 6'h01 && !analog_out_enable)
    else $error("not in power-on phase after reset");
  poc_tristate_a: assert property (state_out == 6'h01 && $past(state_out) == 6'h01
    |-> !analog_out_enable)
    else $error("pin driven in power-on phase");
  eeprom_low_a: assert property (state_out == 6'h02 && $past(state_out) == 6'h02
    |-> analog_out_enable && analog_out_low)
    else $error("pin not low in eeprom phase");
  diag_level_a: assert property (state_out == 6'h20 && $past(state_out) == 6'h20
    |-> analog_out_enable && analog_out_low && dac_code == 15'h0 && serial_out == 16'hdead)
    else $error("diagnostic outputs wrong");
  serial_match_a: assert property (state_out == 6'h08 && $past(state_out) == 6'h08
    |-> serial_out == {1'b0, dac_code})
    else $error("serial result differs from dac code");
  // ****
  // command entry
  // ****
  cmd_entry_a: assert property (onewire_cmd_valid && onewire_accept
    && state_out == 6'h08 |-> ##2 state_out == 6'h10)
    else $error("accepted command not entered");
  ow_ignored_a: assert property (onewire_cmd_valid && !onewire_accept && !i2c_cmd_valid
    && state_out == 6'h08 |-> ##2 state_out != 6'h10)
    else $error("refused command entered");
  cmd_hold_a: assert property (state_out == 6'h10 |=> state_out == 6'h10)
    else $error("command state left");
  cover property (state_out == 6'h10);
  cover property (state_out == 6'h20);
  cover property (state_out == 6'h08 && analog_out_enable && !analog_out_low);
endmodule
`default_nettype wire

// *** testbench/cal_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cal_master_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       send_ow,
  input  wire logic       send_i2c,
  input  wire logic [3:0] lag,
  output var  logic       onewire_cmd_valid,
  output var  logic       i2c_cmd_valid
);
  logic [3:0] cnt_r;
  logic       busy_r;
  logic       i2c_r;
  // ****
  // command sender, prompt or late
  // ****
  always_ff @(posedge aclk) begin
    onewire_cmd_valid <= 1'b0;
    i2c_cmd_valid     <= 1'b0;
    if (!aresetn) begin
      busy_r <= 1'b0;
      cnt_r  <= 4'h0;
      i2c_r  <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h0) begin
        busy_r            <= 1'b0;
        onewire_cmd_valid <= !i2c_r;
        i2c_cmd_valid     <= i2c_r;
      end
    end else if (send_ow || send_i2c) begin
      busy_r <= 1'b1;
      cnt_r  <= lag;
      i2c_r  <= send_i2c;
    end
  end
endmodule
`default_nettype wire

// *** testbench/conditioner_mode_startup_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cond_ctrl_map.svh"
module conditioner_mode_startup_control_bench;
  localparam int EE = 20, ROM = 40, AON = 30, WIN = 200, ADC = 8;
  logic        aclk = 1'b0, aresetn = 1'b0, send_ow = 1'b0, send_i2c = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  lag = 4'h0;
  wire logic   awready, wready, bvalid, arready, rvalid, ow_v, i2c_v, aen, alow, ow_acc;
  wire logic [1:0]  bresp, rresp, tsel;
  wire logic [31:0] rdata;
  wire logic [14:0] dac;
  wire logic [15:0] sout;
  wire logic [5:0]  st;
  int          err_count = 0, check_count = 0, cyc = 0;

  conditioner_mode_startup_control #(.EE_CYC(EE), .ROMCHK_CYC(ROM), .ANALOG_OUTPUT_PIN_ON_CYC(AON),
    .WINDOW_CYC(WIN), .AD_CONV_CYC(ADC)) u_conditioner_mode_startup_control (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .onewire_cmd_valid(ow_v), .i2c_cmd_valid(i2c_v), .analog_out_enable(aen),
    .analog_out_low(alow), .dac_code(dac), .serial_out(sout), .onewire_accept(ow_acc),
    .temp_source_sel(tsel), .state_out(st));
  cal_master_model u_cal_master_model (.aclk(aclk), .aresetn(aresetn), .send_ow(send_ow),
    .send_i2c(send_i2c), .lag(lag), .onewire_cmd_valid(ow_v), .i2c_cmd_valid(i2c_v));

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  // ****
  // helpers
  // ****
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic boot(input logic [31:0] c, output int ee, output logic [1:0] pin, output int t0);
    logic [1:0] r;
    do_reset();
    wr(`ADDR_CTRL, c, r);
    t0 = cyc;
    ee = 0;
    pin = 2'h0;
    repeat (400) begin
      @(posedge aclk);
      if (st == 6'h02) ee++;
      if (st == 6'h04) pin = {aen, alow};
      if (st == 6'h08 || st == 6'h20) break;
    end
  endtask
  task automatic ow(input logic i2c);
    lag <= 4'($urandom_range(3));
    send_ow <= !i2c;
    send_i2c <= i2c;
    @(posedge aclk);
    send_ow <= 1'b0;
    send_i2c <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  function automatic logic [31:0] ctrl_word(input int m, input logic rc, input logic [1:0] ts,
    input logic ok, input logic er);
    return {21'h0, er, 1'b0, ok, 2'h2, ts, 2'(m), rc, 1'b1};
  endfunction
  function automatic logic [1:0] start_pin(input int m);
    return (m == cond_ctrl_pkg::onewire_disabled_mode
      || m == cond_ctrl_pkg::analog_with_window_mode) ? 2'b11 : 2'b00;
  endfunction
  function automatic logic on_ok(input int m, input int d);
    if (m == cond_ctrl_pkg::onewire_always_mode) return d == 0;
    if (m == cond_ctrl_pkg::window_only_mode) return d >= WIN - 4;
    return d > 0 && d < WIN;
  endfunction
  // ****
  // tests
  // ****
  initial begin
    int ee, t0, d;
    logic [1:0] pin, r, ts;
    logic [31:0] v;
    logic [14:0] lo, hi;
    void'($urandom(32'hf26f59be));
    do_reset();
    check("reset state", 6'h01, st);
    check("reset pin", 2'b00, {aen, alow});
    rd(`ADDR_LIMITS, v, r);
    check("limits", {1'b0, `LIM_HI_RESET, 1'b0, `LIM_LO_RESET}, v);
    rd(`ADDR_ERRCODE, v, r);
    check("error code", {16'h0, `DIAG_ERR_CODE}, v);
    rd(12'h100, v, r);
    check("unmapped read", 2'h2, r);
    wr(12'h100, 32'hffffffff, r);
    check("unmapped write", 2'h2, r);
    $display("test registers done");
    for (int m = 0; m < 4; m++) for (int rc = 0; rc < 2; rc++) begin
      ts = 2'($urandom_range(3));
      boot(ctrl_word(m, rc[0], ts, 1'b1, 1'b0), ee, pin, t0);
      check("rom phase", rc, 32'(ee >= ROM));
      check("start pin", start_pin(m), pin);
      check("running", 6'h08, st);
      check("temp source", ts, tsel);
      check("accept early", m != 1, ow_acc);
      d = 0;
      repeat (WIN + 20) begin
        @(posedge aclk);
        if (aen && !alow && d == 0) d = cyc - t0;
      end
      check("analog on", 1'b1, on_ok(m, d));
      check("accept late", m == 0, ow_acc);
      ow(1'b0);
      check("late command", m == 0 ? 6'h10 : 6'h08, st);
    end
    $display("test modes done");
    for (int k = 1; k < 4; k++) begin
      boot(ctrl_word(k, 1'b0, 2'h0, 1'b1, 1'b0), ee, pin, t0);
      ow(k == 1);
      check("command entry", 6'h10, st);
    end
    $display("test command done");
    boot(ctrl_word(1, 1'b0, 2'h1, 1'b1, 1'b0), ee, pin, t0);
    for (int i = 0; i < 6; i++) begin
      lo = 15'($urandom_range(32'h7fff));
      hi = i[0] ? lo + 15'($urandom_range(32'h7fff - lo)) : lo;
      wr(`ADDR_LIMITS, {1'b0, hi, 1'b0, lo}, r);
      wr(`ADDR_RAW, $urandom, r);
      repeat (200) begin
        @(posedge aclk);
        if (dac >= lo && dac <= hi) break;
      end
      repeat (2) @(posedge aclk);
      check("clip range", 1'b1, dac >= lo && dac <= hi);
      if (!i[0]) check("clip fixed", {1'b0, lo}, sout);
      rd(`ADDR_RESULT, v, r);
      check("result reg", {16'h0, sout}, v);
    end
    $display("test clipping done");
    for (int e = 0; e < 2; e++) begin
      boot(ctrl_word(3, 1'b0, 2'h0, e[0], e[0]), ee, pin, t0);
      repeat (2) @(posedge aclk);
      check("diag state", 6'h20, st);
      check("diag pin", 2'b11, {aen, alow});
      check("diag dac", 15'h0, dac);
      check("diag serial", `DIAG_ERR_CODE, sout);
    end
    $display("test diagnostic done");
    conclude();
  end
endmodule

bind conditioner_mode_startup_control cond_ctrl_asserts u_cond_ctrl_asserts (.aclk, .aresetn,
  .state_out, .analog_out_enable, .analog_out_low, .dac_code, .serial_out, .onewire_accept,
  .onewire_cmd_valid, .i2c_cmd_valid);
`default_nettype wire
